// file: rtl/csb_cfg.svh
// Timing counts, field values and decode constants for the front-panel supervisor.
// Assumes a 40 MHz system clock and a 1 ms timebase tick.
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH
`define CSB_CLK_NS          25
`define CSB_TICK_NS         1000000
`define CSB_FRAME_MS        12'h03E8
`define CSB_START_MS        12'h03E8
`define CSB_HALF_1HZ_MS     12'h01F4
`define CSB_HALF_2HZ_MS     12'h00FA
`define CSB_HALF_4HZ_MS     12'h007D
`define CSB_SHORT_PRESS_MS  12'h01F4
`define CSB_LONG_PRESS_MS   12'h0BB8
`define CSB_PHASE_MS        12'h0BB8
`define CSB_COUNT_MAX       12'h0FFF
`define CSB_WD_LIMIT_MS     8'hC8
`define CSB_WD_IDLE         8'hFF
`define CSB_WD_ADDR         8'hFF
`define CSB_DEBOUNCE_MS     5'h14
`define CSB_PH_NONE         3'h0
`define CSB_PH_GREEN        3'h1
`define CSB_PH_RED_FAST     3'h2
`define CSB_PH_RED_SLOW     3'h3
`define CSB_PH_RED_GREEN    3'h4
`define CSB_PH_LAST         3'h5
`endif

// file: rtl/csb_debounce.sv
// Synchroniser and debouncer for the active-low run/stop button pin.
// Assumes the pin is asynchronous and bounces for under the debounce time.
`timescale 1ns/100ps
`include "csb_cfg.svh"
module csb_debounce
  import csb_pkg::*;
(
  input  logic    sys_clk,
  input  logic    rst_n,
  input  logic    button_n,
  csb_tick_if.snk tk,
  output logic    pressed
);
  csb_db_s q;
  csb_db_s d;

  always_comb begin
    d    = q;
    d.s1 = button_n;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3 && q.s3 != q.stable_n) begin
      if (tk.ms_tick) begin
        d.cnt = 5'(q.cnt + 5'h01);
      end
      if (q.cnt >= `CSB_DEBOUNCE_MS) begin
        d.stable_n = q.s3;
        d.cnt      = 5'h00;
      end
    end else begin
      d.cnt = 5'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, stable_n: 1'b1, cnt: 5'h00};
    end else begin
      q <= d;
    end
  end

  assign pressed = ~q.stable_n;
endmodule

// file: rtl/csb_pkg.sv
// Types shared by the front-panel supervisor modules.
// Assumes csb_cfg.svh supplies the numeric constants.
package csb_pkg;
  typedef enum logic [7:0] {
    CSB_ST_RESET = 8'h01,
    CSB_ST_START = 8'h02,
    CSB_ST_PUSEQ = 8'h04,
    CSB_ST_BOOT  = 8'h08,
    CSB_ST_RUN   = 8'h10,
    CSB_ST_RCOND = 8'h20,
    CSB_ST_STOP  = 8'h40,
    CSB_ST_HALT  = 8'h80
  } csb_state_e;

  typedef struct packed {
    logic [15:0] cyc;
    logic [11:0] ms;
    logic        tick;
    logic        b1;
    logic        b2;
    logic        b4;
  } csb_tb_s;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic       stable_n;
    logic [4:0] cnt;
  } csb_db_s;

  typedef struct packed {
    csb_state_e  st;
    logic [11:0] start_cnt;
    logic [2:0]  phase;
    logic [11:0] phase_cnt;
    logic [11:0] press_cnt;
    logic        btn_prev;
    logic [7:0]  wd_cnt;
    logic        wd_last;
    logic        wd_close;
    logic        led_g;
    logic        led_r;
    logic        led_y;
    logic        clr_media;
    logic        clr_settings;
    logic        clr_backup;
    logic        clk_preset;
    logic        reload;
  } csb_top_s;
endpackage

// file: rtl/csb_tick_if.sv
// Timebase tick and blink phases passed from the timebase to its users.
// Assumes a single clock domain.
`timescale 1ns/100ps
interface csb_tick_if;
  logic ms_tick;
  logic blink_1hz;
  logic blink_2hz;
  logic blink_4hz;
  modport src (output ms_tick, output blink_1hz, output blink_2hz, output blink_4hz);
  modport snk (input ms_tick, input blink_1hz, input blink_2hz, input blink_4hz);
endinterface

// file: rtl/csb_timebase.sv
// Common 1 ms timebase with 1, 2 and 4 Hz blink phases.
// Assumes sys_clk at the rate given by the tick period.
`timescale 1ns/100ps
`include "csb_cfg.svh"
module csb_timebase
  import csb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `CSB_TICK_NS / `CSB_CLK_NS
) (
  input  logic sys_clk,
  input  logic rst_n,
  csb_tick_if.src tk
);
  csb_tb_s q;
  csb_tb_s d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cyc == 16'(TICK_CYCLES - 1)) begin
      d.cyc  = 16'h0000;
      d.tick = 1'b1;
      d.ms   = (q.ms == `CSB_FRAME_MS - 12'h0001) ? 12'h0000 : 12'(q.ms + 12'h0001);
    end else begin
      d.cyc = 16'(q.cyc + 16'h0001);
    end
    d.b1 = q.ms < `CSB_HALF_1HZ_MS;
    d.b2 = (q.ms < `CSB_HALF_2HZ_MS) || (q.ms >= `CSB_HALF_1HZ_MS && q.ms < 12'(3 * `CSB_HALF_2HZ_MS));
    d.b4 = (q.ms % `CSB_HALF_2HZ_MS) < `CSB_HALF_4HZ_MS;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tk.ms_tick   = q.tick;
  assign tk.blink_1hz = q.b1;
  assign tk.blink_2hz = q.b2;
  assign tk.blink_4hz = q.b4;
endmodule

// file: rtl/csb_top.sv
// Front-panel supervisor: status indicators, run/stop button and watchdog relay.
// Assumes status inputs come from logic on sys_clk; only the button is a raw pin.
// Operation
// RULE1 - Three indicators show state: off, on, blink
// RULE2 - About one second self-diagnosis after restart
// RULE3 - Battery fault flashes error indicator, 500 ms
// RULE4 - Stop on programming unit or debugger
// RULE5 - Halt on stop, fault, or no program
// RULE6 - Hold reset while supply low, firmware down
// RULE7 - Conditional run blinks green; error variants
// RULE8 - Release at green 1 Hz: boot
// RULE9 - Release at red 4 Hz: clear, keep backup
// RULE10 - Release at red 2 Hz: stay stopped
// RULE11 - Release at red/green: clear everything
// RULE12 - Press half to three seconds toggles run
// RULE13 - Press over three seconds reloads program
// RULE14 - Relay closes on output 255 toggling fast
// RULE15 - Relay opens after 200 ms without toggle
// RULE16 - Program inverts helper flag to output 255
// RULE17 - Address 255 decoded outside I/O range
// RULE18 - Button synchronised and debounced first
// RULE19 - All timing from common timebase counter
`timescale 1ns/100ps
`include "csb_cfg.svh"
module csb_top
  import csb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `CSB_TICK_NS / `CSB_CLK_NS
) (
  input  logic       sys_clk,
  input  logic       rst_n,
  input  logic       button_n,
  input  logic       supply_low,
  input  logic       fw_started,
  input  logic       restart_req,
  input  logic       programming_unit_mode,
  input  logic       pgu_stop_cmd,
  input  logic       pgu_run_cmd,
  input  logic       debugger_run_until_condition,
  input  logic       run_until_met,
  input  logic       stop_instr,
  input  logic       serious_error,
  input  logic       hw_fault,
  input  logic       program_loaded,
  input  logic       error_present,
  input  logic       battery_fault,
  input  logic       io_wr,
  input  logic [7:0] io_addr,
  input  logic       io_wdata,
  output logic       led_green,
  output logic       led_red,
  output logic       led_yellow,
  output logic       wd_relay_close,
  output logic [7:0] cpu_state,
  output logic       clear_media_req,
  output logic       clear_settings_req,
  output logic       clear_backup_req,
  output logic       clock_preset_req,
  output logic       reload_program_req
);

  csb_tick_if tk ();

  logic       btn_pressed;
  csb_top_s   q;
  csb_top_s   d;

  // RULE19 shared timebase
  csb_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tk      (tk.src)
  );

  // RULE18 clean button level
  csb_debounce u_debounce (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .button_n (button_n),
    .tk       (tk.snk),
    .pressed  (btn_pressed)
  );

  logic       hold_reset;
  logic       halt_cause;
  logic       btn_release;
  logic       short_press;
  logic       long_press;
  logic       wd_hit;
  csb_state_e start_target;

  always_comb begin
    d              = q;
    d.clr_media    = 1'b0;
    d.clr_settings = 1'b0;
    d.clr_backup   = 1'b0;
    d.clk_preset   = 1'b0;
    d.reload       = 1'b0;

    // RULE6 reset causes
    hold_reset = supply_low || !fw_started;
    // RULE5 halt causes
    halt_cause = stop_instr || serious_error || hw_fault || !program_loaded;

    // RULE5 where a normal start lands
    if (!program_loaded) begin
      start_target = CSB_ST_HALT;
    end else if (programming_unit_mode) begin
      // RULE4 unit attached at power-on
      start_target = CSB_ST_STOP;
    end else if (debugger_run_until_condition && !run_until_met) begin
      start_target = CSB_ST_RCOND;
    end else begin
      start_target = CSB_ST_RUN;
    end

    // Press length in ms, saturating
    btn_release = q.btn_prev && !btn_pressed;
    d.btn_prev  = btn_pressed;
    if (!btn_pressed) begin
      d.press_cnt = 12'h0000;
    end else if (tk.ms_tick && q.press_cnt != `CSB_COUNT_MAX) begin
      d.press_cnt = 12'(q.press_cnt + 12'h0001);
    end
    short_press = btn_release && q.press_cnt > `CSB_SHORT_PRESS_MS && q.press_cnt < `CSB_LONG_PRESS_MS;
    long_press  = btn_release && q.press_cnt > `CSB_LONG_PRESS_MS;

    // RULE17 exact match on 255, independent of I/O range
    wd_hit = io_wr && io_addr == `CSB_WD_ADDR;
    if (wd_hit && io_wdata != q.wd_last) begin
      d.wd_last = io_wdata;
      d.wd_cnt  = 8'h00;
      // RULE14 close on fast toggle
      if (q.wd_cnt < `CSB_WD_LIMIT_MS) begin
        d.wd_close = 1'b1;
      end
    end else if (tk.ms_tick && q.wd_cnt != `CSB_WD_IDLE) begin
      d.wd_cnt = 8'(q.wd_cnt + 8'h01);
      // RULE15 open once 200 ms exceeded
      if (q.wd_cnt >= `CSB_WD_LIMIT_MS) begin
        d.wd_close = 1'b0;
      end
    end

    // Operating state sequence
    case (q.st)
      CSB_ST_RESET: begin
        if (!hold_reset) begin
          d.st        = CSB_ST_START;
          d.start_cnt = 12'h0000;
        end
      end

      CSB_ST_START: begin
        // RULE2 timed self-diagnosis
        if (tk.ms_tick) begin
          d.start_cnt = 12'(q.start_cnt + 12'h0001);
        end
        if (q.start_cnt >= `CSB_START_MS) begin
          if (btn_pressed) begin
            d.st        = CSB_ST_PUSEQ;
            d.phase     = `CSB_PH_NONE;
            d.phase_cnt = 12'h0000;
          end else begin
            d.st = start_target;
          end
        end
      end

      CSB_ST_PUSEQ: begin
        if (tk.ms_tick) begin
          d.phase_cnt = 12'(q.phase_cnt + 12'h0001);
        end
        if (q.phase_cnt >= `CSB_PHASE_MS && q.phase != `CSB_PH_LAST) begin
          d.phase     = 3'(q.phase + 3'h1);
          d.phase_cnt = 12'h0000;
        end
        if (btn_release) begin
          case (q.phase)
            `CSB_PH_GREEN: begin
              // RULE8 wait for firmware download
              d.st = CSB_ST_BOOT;
            end
            `CSB_PH_RED_FAST: begin
              // RULE9 clear, preset clock, keep backup
              d.clr_media    = 1'b1;
              d.clr_settings = 1'b1;
              d.clk_preset   = 1'b1;
              d.st           = CSB_ST_HALT;
            end
            `CSB_PH_RED_SLOW: begin
              // RULE10 no program start
              d.st = CSB_ST_STOP;
            end
            `CSB_PH_RED_GREEN: begin
              // RULE11 clear incl. backup, no card copy
              d.clr_media    = 1'b1;
              d.clr_settings = 1'b1;
              d.clr_backup   = 1'b1;
              d.st           = CSB_ST_HALT;
            end
            default: begin
              d.st = start_target;
            end
          endcase
        end
      end

      CSB_ST_BOOT: begin
        d.st = CSB_ST_BOOT;
      end

      CSB_ST_RUN: begin
        if (halt_cause) begin
          d.st = CSB_ST_HALT;
        end else if (pgu_stop_cmd || short_press) begin
          // RULE4 stop by programming unit
          // RULE12 toggle to stop
          d.st = CSB_ST_STOP;
        end else if (debugger_run_until_condition && !run_until_met) begin
          // RULE7 enter conditional run
          d.st = CSB_ST_RCOND;
        end
      end

      CSB_ST_RCOND: begin
        if (halt_cause) begin
          d.st = CSB_ST_HALT;
        end else if (run_until_met || pgu_stop_cmd || short_press) begin
          // RULE4 debugger condition fulfilled
          d.st = CSB_ST_STOP;
        end else if (!debugger_run_until_condition) begin
          d.st = CSB_ST_RUN;
        end
      end

      CSB_ST_STOP: begin
        if (hw_fault || serious_error) begin
          d.st = CSB_ST_HALT;
        end else if (program_loaded && (pgu_run_cmd || short_press)) begin
          // RULE12 toggle to run
          d.st = CSB_ST_RUN;
        end
      end

      CSB_ST_HALT: begin
        if (program_loaded && pgu_run_cmd && !halt_cause) begin
          d.st = CSB_ST_RUN;
        end
      end

      default: begin
        d.st = CSB_ST_RESET;
      end
    endcase

    // RULE13 reload after long press
    if (long_press && (q.st == CSB_ST_RUN || q.st == CSB_ST_RCOND || q.st == CSB_ST_STOP)) begin
      d.reload    = 1'b1;
      d.st        = CSB_ST_START;
      d.start_cnt = 12'h0000;
    end

    // RULE2 restart re-enters diagnosis
    if (restart_req && q.st != CSB_ST_RESET) begin
      d.st        = CSB_ST_START;
      d.start_cnt = 12'h0000;
    end

    // RULE6 reset overrides every state change
    if (hold_reset) begin
      d.st = CSB_ST_RESET;
    end

    // RULE1 indicator patterns per state
    case (q.st)
      CSB_ST_START: begin
        d.led_g = tk.blink_4hz;
        d.led_r = tk.blink_4hz;
      end
      CSB_ST_PUSEQ: begin
        case (q.phase)
          `CSB_PH_GREEN: begin
            d.led_g = tk.blink_1hz;
            d.led_r = 1'b0;
          end
          `CSB_PH_RED_FAST: begin
            d.led_g = 1'b0;
            d.led_r = tk.blink_4hz;
          end
          `CSB_PH_RED_SLOW: begin
            d.led_g = 1'b0;
            d.led_r = tk.blink_2hz;
          end
          `CSB_PH_RED_GREEN: begin
            d.led_g = ~tk.blink_2hz;
            d.led_r = tk.blink_2hz;
          end
          default: begin
            d.led_g = 1'b1;
            d.led_r = 1'b1;
          end
        endcase
      end
      CSB_ST_BOOT: begin
        d.led_g = tk.blink_1hz;
        d.led_r = tk.blink_1hz;
      end
      CSB_ST_RUN: begin
        d.led_g = 1'b1;
        d.led_r = 1'b0;
      end
      CSB_ST_RCOND: begin
        // RULE7 green blinks while waiting
        d.led_g = tk.blink_1hz;
        d.led_r = 1'b0;
      end
      CSB_ST_STOP: begin
        d.led_g = 1'b0;
        d.led_r = 1'b1;
      end
      CSB_ST_HALT: begin
        d.led_g = 1'b0;
        d.led_r = tk.blink_2hz;
      end
      default: begin
        d.led_g = 1'b0;
        d.led_r = 1'b0;
      end
    endcase

    if (q.st == CSB_ST_RESET) begin
      d.led_y = 1'b0;
    end else if (q.st == CSB_ST_START) begin
      d.led_y = tk.blink_4hz;
    end else if (battery_fault) begin
      // RULE3 500 ms flash
      d.led_y = tk.blink_1hz;
    end else begin
      // RULE7 error variant of each state after start
      d.led_y = error_present;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      q.st        <= CSB_ST_RESET;
      q.wd_cnt    <= `CSB_WD_IDLE;
    end else begin
      q <= d;
    end
  end

  assign led_green          = q.led_g;
  assign led_red            = q.led_r;
  assign led_yellow         = q.led_y;
  assign wd_relay_close     = q.wd_close;
  assign cpu_state          = q.st;
  assign clear_media_req    = q.clr_media;
  assign clear_settings_req = q.clr_settings;
  assign clear_backup_req   = q.clr_backup;
  assign clock_preset_req   = q.clk_preset;
  assign reload_program_req = q.reload;

endmodule

// file: testbench/csb_prog_model.sv
// Stand-in user program that toggles the watchdog output.
// Assumes the bench sets the period in clocks and the target address.
`timescale 1ns/100ps
module csb_prog_model (
  input  logic        sys_clk,
  input  logic        rst_n,
  input  logic        run,
  input  logic [15:0] period,
  input  logic [7:0]  wd_addr,
  output logic        io_wr,
  output logic [7:0]  io_addr,
  output logic        io_wdata
);
  logic [15:0] cnt_q;
  logic        flag_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cnt_q, flag_q, io_wr, io_addr, io_wdata} <= '0;
    end else if (run && cnt_q >= period) begin
      flag_q   <= ~flag_q;
      io_wdata <= ~flag_q;
      io_addr  <= wd_addr;
      io_wr    <= 1'b1;
      cnt_q    <= '0;
    end else begin
      // Idle bus carries no stale value
      io_wr    <= 1'b0;
      io_addr  <= ~io_addr;
      io_wdata <= ~io_wdata;
      cnt_q    <= cnt_q + 1'b1;
    end
  end
endmodule

// file: testbench/csb_top_monitor.sv
// Checker on the front-panel supervisor top ports.
// Assumes one clock domain; bound into every csb_top instance.
`timescale 1ns/100ps
module csb_top_monitor #(
  parameter int unsigned TICK_CYCLES = 40000
) (
  input logic       sys_clk,
  input logic       rst_n,
  input logic       supply_low,
  input logic       fw_started,
  input logic       io_wr,
  input logic [7:0] io_addr,
  input logic       led_green,
  input logic       led_red,
  input logic       led_yellow,
  input logic       wd_relay_close,
  input logic [7:0] cpu_state,
  input logic       clear_backup_req,
  input logic       clock_preset_req,
  input logic       reload_program_req
);
  int unsigned wd_age_q;
  int unsigned st_age_q;

  // Cycles since a watchdog write, and cycles spent in start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_age_q <= 0;
      st_age_q <= 0;
    end else begin
      wd_age_q <= (io_wr && io_addr == 8'hFF) ? 0 : wd_age_q + 1;
      st_age_q <= (cpu_state == 8'h02) ? st_age_q + 1 : 0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_hold;
    supply_low || !fw_started;
  endsequence
  sequence s_in_run;
    cpu_state == 8'h10 [*3];
  endsequence

  chk_hold_reset: assert property (s_hold |=> cpu_state == 8'h01)
    else $error("state left reset while held");
  chk_reset_dark: assert property (cpu_state == 8'h01 [*3] |-> !(led_green || led_red || led_yellow))
    else $error("indicator lit in reset");
  chk_run_green: assert property (s_in_run |-> led_green && !led_red)
    else $error("run indicators wrong");
  chk_wd_cause: assert property ($rose(wd_relay_close) |-> wd_age_q == 0)
    else $error("relay closed without watchdog write");
  chk_wd_open: assert property (wd_relay_close |-> wd_age_q <= 202 * TICK_CYCLES + 3)
    else $error("relay held past watchdog limit");
  chk_start_len: assert property (cpu_state == 8'h02 |-> st_age_q <= 1001 * TICK_CYCLES + 4)
    else $error("start state too long");
  chk_keep_backup: assert property (clock_preset_req |-> (!clear_backup_req) [*4])
    else $error("backup cleared with clock preset");
  chk_wipe_halt: assert property (clear_backup_req |-> ##[0:3] cpu_state == 8'h80)
    else $error("no halt after full wipe");
  chk_reload_start: assert property (reload_program_req |-> ##[0:2] cpu_state == 8'h02)
    else $error("no restart after reload");
endmodule

bind csb_top csb_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (.sys_clk, .rst_n, .supply_low, .fw_started,
  .io_wr, .io_addr, .led_green, .led_red, .led_yellow, .wd_relay_close, .cpu_state, .clear_backup_req,
  .clock_preset_req, .reload_program_req);

// file: testbench/csb_top_tb_top.sv
// Self-checking bench for the front-panel supervisor.
// Assumes csb_top, its checker and the program model are compiled first.
`timescale 1ns/100ps
module csb_top_tb_top;
  import csb_pkg::*;
  localparam int TK = 2;
  logic sys_clk, rst_n, button_n, supply_low, fw_started, restart_req, programming_unit_mode;
  logic pgu_stop_cmd, pgu_run_cmd, debugger_run_until_condition, run_until_met, stop_instr;
  logic serious_error, hw_fault, program_loaded, error_present, battery_fault, io_wr, io_wdata;
  logic led_green, led_red, led_yellow, wd_relay_close, clear_media_req, clear_settings_req;
  logic clear_backup_req, clock_preset_req, reload_program_req, clr, wd_run;
  logic [7:0]  io_addr, cpu_state, wd_adr;
  logic [15:0] wd_per;
  logic [4:0]  seen;
  int          fails, checked;

  csb_top #(.TICK_CYCLES(TK)) dut_u (.sys_clk, .rst_n, .button_n, .supply_low, .fw_started, .restart_req,
    .programming_unit_mode, .pgu_stop_cmd, .pgu_run_cmd, .debugger_run_until_condition, .run_until_met,
    .stop_instr, .serious_error, .hw_fault, .program_loaded, .error_present, .battery_fault, .io_wr, .io_addr,
    .io_wdata, .led_green, .led_red, .led_yellow, .wd_relay_close, .cpu_state, .clear_media_req,
    .clear_settings_req, .clear_backup_req, .clock_preset_req, .reload_program_req);
  csb_prog_model prog_u (.sys_clk, .rst_n, .run(wd_run), .period(wd_per), .wd_addr(wd_adr), .io_wr, .io_addr,
    .io_wdata);

  always #12.5 sys_clk = ~sys_clk;
  // Sticky record of request pulses
  always @(posedge sys_clk)
    seen <= (clr || !rst_n) ? 5'h00 : seen | {clear_media_req, clear_settings_req, clear_backup_req, clock_preset_req,
                                  reload_program_req};

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(int n);
    repeat (n * TK) @(posedge sys_clk);
  endtask
  task automatic wait_st(logic [7:0] s, int lim);
    int n;
    n = 0;
    while (cpu_state !== s && n < lim * TK) begin
      @(posedge sys_clk);
      n++;
    end
    chk("cpu_state", cpu_state, s);
    if (cpu_state !== s) summarize();
  endtask
  task automatic press(int n);
    button_n <= 1'b0;
    wt(n);
    button_n <= 1'b1;
    wt(40);
  endtask
  task automatic duty(logic g, output int n);
    n = 0;
    repeat (1000 * TK) begin
      @(posedge sys_clk);
      n += g ? led_green : led_yellow;
    end
  endtask
  task automatic clear_seen();
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask
  task automatic go_run();
    pgu_run_cmd <= 1'b1;
    wait_st(8'h10, 5);
    pgu_run_cmd <= 1'b0;
  endtask

  task automatic t_boot();
    int n;
    wt(5);
    chk("cpu_state", cpu_state, 8'h01);
    chk("leds", {led_green, led_red, led_yellow}, 3'h0);
    fw_started <= 1'b1;
    wait_st(8'h02, 2);
    for (n = 0; cpu_state !== 8'h10 && n < 1100 * TK; n++) @(posedge sys_clk);
    chk("start length", 16'((n >= 999 * TK) && (n <= 1001 * TK + 4)), 16'h0001);
    wt(2);
    chk("leds", {led_green, led_red}, 2'h2);
  endtask
  task automatic t_wd();
    {wd_adr, wd_per, wd_run} <= {8'hFF, 16'(100 * TK), 1'b1};
    wt(350);
    chk("relay", wd_relay_close, 1'b1);
    wd_run <= 1'b0;
    wt(90);
    chk("relay", wd_relay_close, 1'b1);
    wt(130);
    chk("relay", wd_relay_close, 1'b0);
    {wd_per, wd_run} <= {16'(250 * TK), 1'b1};
    wt(800);
    chk("relay", wd_relay_close, 1'b0);
    {wd_adr, wd_per} <= {8'hFE, 16'(100 * TK)};
    wt(400);
    chk("relay", wd_relay_close, 1'b0);
    wd_run <= 1'b0;
  endtask
  task automatic t_btn();
    press(200);
    chk("cpu_state", cpu_state, 8'h10);
    press(1000);
    chk("cpu_state", cpu_state, 8'h40);
    chk("leds", {led_green, led_red}, 2'h1);
    press(1000);
    chk("cpu_state", cpu_state, 8'h10);
    clear_seen();
    press(3500);
    chk("reload", seen[0], 1'b1);
    chk("cpu_state", cpu_state, 8'h02);
    wait_st(8'h10, 1100);
  endtask
  task automatic t_yel();
    int n;
    error_present <= 1'b1;
    wt(3);
    chk("yellow", led_yellow, 1'b1);
    battery_fault <= 1'b1;
    wt(3);
    duty(1'b0, n);
    chk("yellow duty", 16'(n / 10), 16'(50 * TK));
    {battery_fault, error_present} <= 2'h0;
  endtask
  task automatic t_halt();
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: stop_instr <= 1'b1;
        1: serious_error <= 1'b1;
        2: hw_fault <= 1'b1;
        default: program_loaded <= 1'b0;
      endcase
      wait_st(8'h80, 5);
      {stop_instr, serious_error, hw_fault, program_loaded} <= 4'h1;
      go_run();
    end
  endtask
  task automatic t_dbg();
    int n;
    debugger_run_until_condition <= 1'b1;
    wait_st(8'h20, 5);
    wt(3);
    duty(1'b1, n);
    chk("green duty", 16'(n / 10), 16'(50 * TK));
    run_until_met <= 1'b1;
    wait_st(8'h40, 5);
    {debugger_run_until_condition, run_until_met} <= 2'h0;
    go_run();
    pgu_stop_cmd <= 1'b1;
    wait_st(8'h40, 5);
    pgu_stop_cmd <= 1'b0;
    go_run();
    {programming_unit_mode, supply_low} <= 2'h3;
    wait_st(8'h01, 5);
    supply_low <= 1'b0;
    wait_st(8'h40, 1100);
    programming_unit_mode <= 1'b0;
    go_run();
  endtask
  task automatic t_pup();
    logic [7:0] st [5] = '{8'h10, 8'h08, 8'h80, 8'h40, 8'h80};
    logic [3:0] pl [5] = '{4'h0, 4'h0, 4'hD, 4'h0, 4'hE};
    for (int k = 0; k <= 4; k++) begin
      {button_n, restart_req} <= 2'h1;
      wait_st(8'h02, 5);
      restart_req <= 1'b0;
      wait_st(8'h04, 1100);
      clear_seen();
      wt(k * 3000 + 100);
      button_n <= 1'b1;
      wt(30);
      chk("cpu_state", cpu_state, st[k]);
      chk("pulses", seen[4:1], pl[k]);
    end
  endtask

  initial begin
    {sys_clk, rst_n, supply_low, fw_started, restart_req, programming_unit_mode, pgu_stop_cmd} = '0;
    {pgu_run_cmd, debugger_run_until_condition, run_until_met, stop_instr, serious_error} = '0;
    {hw_fault, error_present, battery_fault, clr, wd_run, wd_adr, wd_per} = '0;
    {button_n, program_loaded} = 2'h3;
    fails = 0;
    checked = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_boot();
    t_wd();
    t_btn();
    t_yel();
    t_halt();
    t_dbg();
    t_pup();
    summarize();
  end
endmodule
